// ### bench/tb_tsa_aux_regs.sv
// self-checking bench for the trigger sequencer aux register bank
`default_nettype none
module tb_tsa_aux_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import tsa_pkg::*;

  // stimulus, all given a value at time zero
  logic        clk_i = 1'b0, rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0]  wb_sel_i = 4'h0;
  logic        add_adjust_command_i = 1'b0, control_step_command_i = 1'b0;
  tsa_target_t add_target_i = TSA_TGT_TIMER_LIMIT;
  logic [15:0] add_operand_i = 16'h0;
  logic        step_index_load_i = 1'b0;
  logic [4:0]  step_index_i = 5'h00;
  // observed
  logic        wb_ack_o, generator_enable_o, generator_start_o, add_sum_valid_o;
  logic        adc_channel_select_wr_o;
  logic [31:0] wb_dat_o;
  tsa_target_t add_sum_target_o;
  logic [15:0] add_sum_o, adc_channel_select_o;
  logic [4:0]  step_queue_index_o;
  logic [7:0]  step_cmd_byte_o;
  int          bad_count = 0, checks = 0;

  tsa_aux_regs dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .generator_enable_o(generator_enable_o),
    .generator_start_o(generator_start_o), .add_adjust_command_i(add_adjust_command_i),
    .add_target_i(add_target_i), .add_operand_i(add_operand_i),
    .add_sum_valid_o(add_sum_valid_o), .add_sum_target_o(add_sum_target_o),
    .add_sum_o(add_sum_o), .control_step_command_i(control_step_command_i),
    .adc_channel_select_wr_o(adc_channel_select_wr_o),
    .adc_channel_select_o(adc_channel_select_o), .step_index_load_i(step_index_load_i),
    .step_index_i(step_index_i), .step_queue_index_o(step_queue_index_o),
    .step_cmd_byte_o(step_cmd_byte_o));

  // 125 MHz clock
  initial begin
    forever #4 clk_i = ~clk_i;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one classic cycle; the request stands until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [31:0] rd);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] x;
    wb(1'b1, a, d, s, x);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    wb(1'b0, a, 32'h0, 4'hF, x);
    chk(nm, x, e);
  endtask

  task automatic t_reset;
    rdc("adjust", TSA_OFS_ADJUST, 32'h0);
    rdc("literal", TSA_OFS_LITERAL, 32'h0);
    rdc("qindex", TSA_OFS_QINDEX, 32'h0);
    rdc("unmapped", 8'h30, 32'h0);
    $display("test reset values done");
  endtask

  // byte lanes and the unused index bits
  task automatic t_regs;
    wr(TSA_OFS_ADJUST, 32'hFFFF1234, 4'hF);
    rdc("adjust", TSA_OFS_ADJUST, 32'h00001234);
    wr(TSA_OFS_LITERAL, 32'h0000ABFF, 4'h1);
    rdc("literal", TSA_OFS_LITERAL, 32'h000000FF);
    wr(TSA_OFS_QINDEX, 32'hFFFFFFFF, 4'hF);
    rdc("qindex", TSA_OFS_QINDEX, 32'h0000001F);
    chk("index out", 32'(step_queue_index_o), 32'h1F);
    $display("test register access done");
  endtask

  // every add target; operands chosen so the three limit sums wrap past 16 bits, the literal sum does not
  task automatic t_add;
    for (int t = 0; t < 4; t++) begin
      @(posedge clk_i);
      add_adjust_command_i <= 1'b1;
      add_target_i <= tsa_target_t'(t);
      add_operand_i <= 16'hF000 + 16'(t);
      @(posedge clk_i);
      add_adjust_command_i <= 1'b0;
      // result pulse stands only for the cycle after the command edge
      #1;
      chk("sum valid", 32'(add_sum_valid_o), 32'h1);
      chk("sum", 32'(add_sum_o), (t == 3) ? 32'h1333 : 32'h0234 + 32'(t));
    end
    rdc("literal sum", TSA_OFS_LITERAL, 32'h00001333);
    @(posedge clk_i);
    control_step_command_i <= 1'b1;
    @(posedge clk_i);
    control_step_command_i <= 1'b0;
    #1;
    chk("adc write", 32'(adc_channel_select_wr_o), 32'h1);
    chk("adc value", 32'(adc_channel_select_o), 32'h1333);
    $display("test commands done");
  endtask

  // enable alone must not lock; enable with start must
  task automatic t_lock;
    wr(TSA_OFS_CONTROL, 32'h3, 4'h1);
    #1;
    chk("run bits", 32'({generator_start_o, generator_enable_o}), 32'h3);
    wr(TSA_OFS_ADJUST, 32'hAAAA, 4'h3);
    wr(TSA_OFS_LITERAL, 32'h5555, 4'h3);
    wr(TSA_OFS_QINDEX, 32'h0, 4'h3);
    rdc("locked adjust", TSA_OFS_ADJUST, 32'h1234);
    rdc("locked literal", TSA_OFS_LITERAL, 32'h1333);
    rdc("locked qindex", TSA_OFS_QINDEX, 32'h1F);
    wr(TSA_OFS_CONTROL, 32'h1, 4'h1);
    wr(TSA_OFS_ADJUST, 32'h0005, 4'h3);
    rdc("open adjust", TSA_OFS_ADJUST, 32'h5);
    wr(TSA_OFS_CONTROL, 32'h0, 4'h1);
    $display("test lock done");
  endtask

  // queue word survives a mid-run reset, then feeds the command byte
  task automatic t_queue;
    wr(8'h44, 32'h0000BEEF, 4'h3);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc("queue word", 8'h44, 32'h0000BEEF);
    rdc("adjust cleared", TSA_OFS_ADJUST, 32'h0);
    @(posedge clk_i);
    step_index_load_i <= 1'b1;
    step_index_i <= 5'h03;
    @(posedge clk_i);
    step_index_load_i <= 1'b0;
    @(posedge clk_i);
    #1;
    chk("index load", 32'(step_queue_index_o), 32'h3);
    @(posedge clk_i);
    #1;
    chk("cmd byte", 32'(step_cmd_byte_o), 32'hBE);
    $display("test queue done");
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_regs();
    t_add();
    t_lock();
    t_queue();
    wrap_up();
  end

  // watchdog: the tests need little more than a hundred cycles
  initial begin
    repeat (5000) @(posedge clk_i);
    bad_count++;
    wrap_up();
  end
endmodule // tb_tsa_aux_regs
`default_nettype wire

// ### bench/tsa_aux_regs_props.sv
// concurrent checks on the ports of the trigger sequencer aux register bank
`default_nettype none
module tsa_aux_regs_props
  import tsa_pkg::*;
#(
  parameter int unsigned QWORDS = tsa_pkg::TSA_QWORDS
) (
  // clock and reset
  input wire logic                          clk_i,
  input wire logic                          rst_i,
  // wishbone slave
  input wire logic                          wb_cyc_i,
  input wire logic                          wb_stb_i,
  input wire logic                          wb_we_i,
  input wire logic [tsa_pkg::TSA_ADR_W-1:0] wb_adr_i,
  input wire logic                          wb_ack_o,
  input wire logic [tsa_pkg::TSA_DAT_W-1:0] wb_dat_o,
  // run state and commands
  input wire logic                          generator_enable_o,
  input wire logic                          generator_start_o,
  input wire logic                          add_adjust_command_i,
  input wire tsa_pkg::tsa_target_t          add_target_i,
  input wire logic                          add_sum_valid_o,
  input wire tsa_pkg::tsa_target_t          add_sum_target_o,
  input wire logic                          control_step_command_i,
  input wire logic                          adc_channel_select_wr_o,
  input wire logic [tsa_pkg::TSA_REG_W-1:0] adc_channel_select_o,
  // queue position
  input wire logic                          step_index_load_i,
  input wire logic [tsa_pkg::TSA_IDX_W-1:0] step_index_i,
  input wire logic [tsa_pkg::TSA_IDX_W-1:0] step_queue_index_o
);
  // one clock domain, so clocking and reset are shared by every check
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack stayed high two cycles");
  ack_after_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered in one cycle");
  add_pulse_a: assert property (add_adjust_command_i |=> add_sum_valid_o &&
    add_sum_target_o == $past(add_target_i)) else $error("add result missing or misrouted");
  add_cause_a: assert property (add_sum_valid_o |-> $past(add_adjust_command_i))
    else $error("add result without command");
  adc_write_a: assert property (control_step_command_i |=> adc_channel_select_wr_o)
    else $error("control step did not write channel select");
  adc_hold_a: assert property (!adc_channel_select_wr_o |-> $stable(adc_channel_select_o))
    else $error("channel select moved without a write");
  lock_hold_a: assert property (generator_enable_o && generator_start_o &&
    !step_index_load_i |=> $stable(step_queue_index_o)) else $error("index moved while locked");
  index_load_a: assert property (step_index_load_i |=>
    step_queue_index_o == $past(step_index_i)) else $error("index load not taken");
  index_upper_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i[7:2] == 6'h03 |->
    wb_dat_o[31:5] == 27'h0000000) else $error("index upper bits not zero");
  reset_clear_a: assert property ($fell(rst_i) |-> !wb_ack_o &&
    step_queue_index_o == 5'h00 && !generator_enable_o) else $error("state not cleared by reset");
endmodule // tsa_aux_regs_props

bind tsa_aux_regs tsa_aux_regs_props #(.QWORDS(QWORDS)) props_u (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
  .generator_enable_o(generator_enable_o), .generator_start_o(generator_start_o),
  .add_adjust_command_i(add_adjust_command_i), .add_target_i(add_target_i),
  .add_sum_valid_o(add_sum_valid_o), .add_sum_target_o(add_sum_target_o),
  .control_step_command_i(control_step_command_i),
  .adc_channel_select_wr_o(adc_channel_select_wr_o), .adc_channel_select_o(adc_channel_select_o),
  .step_index_load_i(step_index_load_i), .step_index_i(step_index_i),
  .step_queue_index_o(step_queue_index_o));
`default_nettype wire

// ### verilog/tsa_aux_regs.sv
// auxiliary register bank of the trigger sequencer: adjust, literal, queue index, queue
// Summary of operation
// RQ1: sixteen-bit adjust value is added into the chosen limit or literal on add command.
// RQ2: sixteen-bit literal is sent to adc channel select on control step command.
// RQ3: adjust, literal and queue index ignore bus writes while enabled and started.
// RQ4: five-bit queue index names the step command currently active.
// RQ5: queue index bits 15 to 5 read zero and ignore writes.
// RQ6: each queue word holds two command bytes and survives every reset.
// RQ7: adjust, literal and queue index clear to zero at reset.
//
// The Wishbone slave port and the register addresses were left to the implementer.
`default_nettype none
module tsa_aux_regs
  import tsa_pkg::*;
#(
  parameter int unsigned QWORDS = tsa_pkg::TSA_QWORDS
) (
  // clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  // wishbone slave
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [tsa_pkg::TSA_ADR_W-1:0] wb_adr_i,
  input  wire logic [tsa_pkg::TSA_DAT_W-1:0] wb_dat_i,
  input  wire logic [tsa_pkg::TSA_SEL_W-1:0] wb_sel_i,
  output logic                               wb_ack_o,
  output logic [tsa_pkg::TSA_DAT_W-1:0]      wb_dat_o,
  // generator run state
  output logic                               generator_enable_o,
  output logic                               generator_start_o,
  // add command from the step decoder
  input  wire logic                          add_adjust_command_i,
  input  wire tsa_pkg::tsa_target_t          add_target_i,
  input  wire logic [tsa_pkg::TSA_REG_W-1:0] add_operand_i,
  output logic                               add_sum_valid_o,
  output tsa_pkg::tsa_target_t               add_sum_target_o,
  output logic [tsa_pkg::TSA_REG_W-1:0]      add_sum_o,
  // control step command toward the adc
  input  wire logic                          control_step_command_i,
  output logic                               adc_channel_select_wr_o,
  output logic [tsa_pkg::TSA_REG_W-1:0]      adc_channel_select_o,
  // queue position from the sequencer
  input  wire logic                          step_index_load_i,
  input  wire logic [tsa_pkg::TSA_IDX_W-1:0] step_index_i,
  output logic [tsa_pkg::TSA_IDX_W-1:0]      step_queue_index_o,
  output logic [7:0]                         step_cmd_byte_o
);
  import tsa_pkg::*;

  localparam int unsigned QIW = $clog2(QWORDS);

  typedef struct packed {
    logic                 enable;
    logic                 start;
    logic [TSA_REG_W-1:0] adjust_value;
    logic [TSA_REG_W-1:0] literal_zero_value;
    logic [TSA_IDX_W-1:0] step_queue_index;
    logic                 sum_valid;
    tsa_target_t          sum_target;
    logic [TSA_REG_W-1:0] sum;
    logic                 adc_wr;
    logic [TSA_REG_W-1:0] adc_sel;
    logic [7:0]           cmd_byte;
  } tsa_aux_state_t;

  tsa_aux_state_t       state_reg;
  tsa_aux_state_t       state_next;
  logic                 bus_wr;
  logic                 locked;
  logic [TSA_DAT_W-1:0] rd_word;
  logic [TSA_REG_W-1:0] queue_rd_word;
  logic [7:0]           queue_cmd_byte;
  logic                 hit_control;
  logic                 hit_adjust;
  logic                 hit_literal;
  logic                 hit_qindex;
  logic                 hit_queue;
  logic [QIW-1:0]       queue_idx;
  logic [TSA_REG_W-1:0] index_merged;

  // bus handshake: ack and read data registered in the port
  tsa_wb_port u_port (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .wb_cyc_i  (wb_cyc_i),
    .wb_stb_i  (wb_stb_i),
    .wb_we_i   (wb_we_i),
    .wb_ack_o  (wb_ack_o),
    .wb_dat_o  (wb_dat_o),
    .wr_o      (bus_wr),
    .rd_data_i (rd_word)
  );

  // address decode; everything else is unmapped and reads zero
  assign hit_control = (wb_adr_i[7:2] == TSA_OFS_CONTROL[7:2]);
  assign hit_adjust  = (wb_adr_i[7:2] == TSA_OFS_ADJUST[7:2]);
  assign hit_literal = (wb_adr_i[7:2] == TSA_OFS_LITERAL[7:2]);
  assign hit_qindex  = (wb_adr_i[7:2] == TSA_OFS_QINDEX[7:2]);
  assign hit_queue   = (wb_adr_i[7:6] == TSA_QUEUE_PAGE);
  assign queue_idx   = wb_adr_i[2 +: QIW];

  // registers freeze only while the sequencer is actually executing
  assign locked = state_reg.enable & state_reg.start; // [RQ3]

  // step queue storage, written over the bus while not locked
  tsa_step_queue #(
    .WORDS (QWORDS)
  ) u_queue (
    .clk_i      (clk_i),
    .wr_i       (bus_wr & hit_queue & ~locked),
    .wr_idx_i   (queue_idx),
    .wr_dat_i   (wb_dat_i),
    .wr_sel_i   (wb_sel_i),
    .rd_idx_i   (queue_idx),
    .rd_word_o  (queue_rd_word),
    .cmd_idx_i  (state_reg.step_queue_index),
    .cmd_byte_o (queue_cmd_byte)
  );

  // read mux; narrow registers sit in the low bits, upper bits zero
  always_comb begin
    rd_word = 32'h0000_0000;
    if (hit_control) begin
      rd_word[TSA_CTL_ENABLE_BIT] = state_reg.enable;
      rd_word[TSA_CTL_START_BIT]  = state_reg.start;
    end else if (hit_adjust) begin
      rd_word[15:0] = state_reg.adjust_value;
    end else if (hit_literal) begin
      rd_word[15:0] = state_reg.literal_zero_value;
    end else if (hit_qindex) begin
      rd_word[4:0] = state_reg.step_queue_index; // [RQ5]
    end else if (hit_queue) begin
      rd_word[15:0] = queue_rd_word;
    end
  end

  // byte-lane merge of the index; only the low five bits are kept
  assign index_merged = tsa_merge16({11'h000, state_reg.step_queue_index}, wb_dat_i, wb_sel_i);

  // next state: bus writes first, hardware events override them
  always_comb begin
    state_next           = state_reg;
    state_next.sum_valid = 1'b0;
    state_next.adc_wr    = 1'b0;
    state_next.cmd_byte  = queue_cmd_byte; // byte of the active step

    // control bits stay writable so software can always stop the sequencer
    if (bus_wr && hit_control && wb_sel_i[0]) begin
      state_next.enable = wb_dat_i[TSA_CTL_ENABLE_BIT];
      state_next.start  = wb_dat_i[TSA_CTL_START_BIT];
    end

    // software writes dropped while running
    if (bus_wr && !locked) begin // [RQ3]
      if (hit_adjust) begin
        state_next.adjust_value = tsa_merge16(state_reg.adjust_value, wb_dat_i, wb_sel_i);
      end
      if (hit_literal) begin
        state_next.literal_zero_value =
          tsa_merge16(state_reg.literal_zero_value, wb_dat_i, wb_sel_i);
      end
      if (hit_qindex) begin
        state_next.step_queue_index = index_merged[4:0]; // [RQ5]
      end
    end

    // add command: sum goes out for outside limits, literal updated here
    if (add_adjust_command_i) begin
      state_next.sum_valid  = 1'b1;
      state_next.sum_target = add_target_i;
      if (add_target_i == TSA_TGT_LITERAL) begin
        state_next.sum = state_reg.literal_zero_value + state_reg.adjust_value; // [RQ1]
        state_next.literal_zero_value = state_next.sum; // [RQ1]
      end else begin
        state_next.sum = add_operand_i + state_reg.adjust_value; // [RQ1]
      end
    end

    // control step command copies the literal toward the adc
    if (control_step_command_i) begin
      state_next.adc_wr  = 1'b1;
      state_next.adc_sel = state_reg.literal_zero_value; // [RQ2]
    end

    // sequencer position wins over a colliding bus write
    if (step_index_load_i) begin
      state_next.step_queue_index = step_index_i; // [RQ4]
    end
  end

  // state register; queue contents live in the queue module without reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg                    <= '0;
      state_reg.enable             <= TSA_ENABLE_RST;
      state_reg.start              <= TSA_START_RST;
      state_reg.adjust_value       <= TSA_ADJUST_RST; // [RQ7]
      state_reg.literal_zero_value <= TSA_LITERAL_RST; // [RQ7]
      state_reg.step_queue_index   <= TSA_QINDEX_RST; // [RQ7]
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs straight from flops
  assign generator_enable_o      = state_reg.enable;
  assign generator_start_o       = state_reg.start;
  assign add_sum_valid_o         = state_reg.sum_valid;
  assign add_sum_target_o        = state_reg.sum_target;
  assign add_sum_o               = state_reg.sum;
  assign adc_channel_select_wr_o = state_reg.adc_wr;
  assign adc_channel_select_o    = state_reg.adc_sel;
  assign step_queue_index_o      = state_reg.step_queue_index; // [RQ4]
  assign step_cmd_byte_o         = state_reg.cmd_byte;

endmodule // tsa_aux_regs
`default_nettype wire

// ### verilog/tsa_pkg.sv
// shared constants, register map and helpers for the trigger sequencer aux registers
`default_nettype none
package tsa_pkg;

  // bus geometry
  localparam int unsigned TSA_ADR_W  = 8;
  localparam int unsigned TSA_DAT_W  = 32;
  localparam int unsigned TSA_SEL_W  = 4;
  localparam int unsigned TSA_REG_W  = 16;
  localparam int unsigned TSA_IDX_W  = 5;
  localparam int unsigned TSA_QWORDS = 16;
  localparam int unsigned TSA_QIDX_W = 4;

  // register byte offsets
  localparam logic [7:0] TSA_OFS_CONTROL = 8'h00;
  localparam logic [7:0] TSA_OFS_ADJUST  = 8'h04;
  localparam logic [7:0] TSA_OFS_LITERAL = 8'h08;
  localparam logic [7:0] TSA_OFS_QINDEX  = 8'h0C;
  // step queue words sit at 0x40 + 4*x, x = 0..15
  localparam logic [1:0] TSA_QUEUE_PAGE  = 2'h1;

  // control register field positions
  localparam int unsigned TSA_CTL_ENABLE_BIT = 0;
  localparam int unsigned TSA_CTL_START_BIT  = 1;

  // values after reset
  localparam logic [15:0] TSA_ADJUST_RST  = 16'h0000;
  localparam logic [15:0] TSA_LITERAL_RST = 16'h0000;
  localparam logic [4:0]  TSA_QINDEX_RST  = 5'h00;
  localparam logic        TSA_ENABLE_RST  = 1'b0;
  localparam logic        TSA_START_RST   = 1'b0;

  // targets of the add command
  typedef enum logic [1:0] {
    TSA_TGT_TIMER_LIMIT   = 2'h0,
    TSA_TGT_COUNTER_LIMIT = 2'h1,
    TSA_TGT_DELAY_LIMIT   = 2'h2,
    TSA_TGT_LITERAL       = 2'h3
  } tsa_target_t;

  // merge the low two byte lanes of a bus write into a 16-bit register
  function automatic logic [15:0] tsa_merge16(input logic [15:0] old_val,
                                             input logic [31:0] wdat,
                                             input logic [3:0]  sel);
    logic [15:0] res;
    res = old_val;
    if (sel[0]) begin
      res[7:0] = wdat[7:0];
    end
    if (sel[1]) begin
      res[15:8] = wdat[15:8];
    end
    return res;
  endfunction

endpackage
`default_nettype wire

// ### verilog/tsa_step_queue.sv
// step queue storage: sixteen words of two command bytes, never reset
`default_nettype none
module tsa_step_queue
  import tsa_pkg::*;
#(
  parameter int unsigned WORDS = tsa_pkg::TSA_QWORDS
) (
  // clock only: contents survive every reset
  input  wire logic                        clk_i,
  // bus write port
  input  wire logic                        wr_i,
  input  wire logic [$clog2(WORDS)-1:0]    wr_idx_i,
  input  wire logic [tsa_pkg::TSA_DAT_W-1:0] wr_dat_i,
  input  wire logic [tsa_pkg::TSA_SEL_W-1:0] wr_sel_i,
  // bus read port
  input  wire logic [$clog2(WORDS)-1:0]    rd_idx_i,
  output logic [tsa_pkg::TSA_REG_W-1:0]    rd_word_o,
  // command byte lookup by byte index
  input  wire logic [$clog2(WORDS):0]      cmd_idx_i,
  output logic [7:0]                       cmd_byte_o
);
  import tsa_pkg::*;

  typedef struct packed {
    logic [WORDS-1:0][TSA_REG_W-1:0] word;
  } tsa_queue_state_t;

  tsa_queue_state_t state_reg;
  tsa_queue_state_t state_next;
  logic [TSA_REG_W-1:0] cmd_word;

  // byte write merge; no reset branch on purpose
  always_comb begin
    state_next = state_reg;
    if (wr_i) begin
      state_next.word[wr_idx_i] = tsa_merge16(state_reg.word[wr_idx_i], wr_dat_i, wr_sel_i);
    end
  end

  always_ff @(posedge clk_i) begin
    state_reg <= state_next; // [RQ6]
  end

  // even step in the low byte, odd step in the high byte
  assign rd_word_o  = state_reg.word[rd_idx_i];
  assign cmd_word   = state_reg.word[cmd_idx_i[$clog2(WORDS):1]];
  assign cmd_byte_o = cmd_idx_i[0] ? cmd_word[15:8] : cmd_word[7:0]; // [RQ6]

endmodule // tsa_step_queue
`default_nettype wire

// ### verilog/tsa_wb_port.sv
// classic wishbone slave handshake with registered ack and read data
`default_nettype none
module tsa_wb_port
  import tsa_pkg::*;
(
  // clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  // wishbone slave side
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  output logic                           wb_ack_o,
  output logic [tsa_pkg::TSA_DAT_W-1:0]  wb_dat_o,
  // register file side
  output logic                           wr_o,
  input  wire logic [tsa_pkg::TSA_DAT_W-1:0] rd_data_i
);
  import tsa_pkg::*;

  typedef struct packed {
    logic                 ack;
    logic [TSA_DAT_W-1:0] dat;
  } tsa_port_state_t;

  tsa_port_state_t state_reg;
  tsa_port_state_t state_next;
  logic            req;

  // one wait state: ack rises one edge after the request, drops the edge after
  assign req = wb_cyc_i & wb_stb_i & ~state_reg.ack;

  always_comb begin
    state_next     = state_reg;
    state_next.ack = req;
    if (req) begin
      state_next.dat = rd_data_i; // read data captured together with ack
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // writes commit on the edge where the master sees ack
  assign wr_o     = wb_cyc_i & wb_stb_i & wb_we_i & state_reg.ack;
  assign wb_ack_o = state_reg.ack;
  assign wb_dat_o = state_reg.dat;

endmodule // tsa_wb_port
`default_nettype wire
